// >>> logic/crb_pkg.sv
package crb_pkg;

    localparam int ADDR_W     = 12;
    localparam int OFS_W      = 7;
    localparam int BANK_W     = 5;
    localparam int BANKS      = 32;
    localparam int BANK_BYTES = 128;

    // core register offsets, same in every bank
    localparam logic [6:0] OFS_IND0   = 7'h00;
    localparam logic [6:0] OFS_IND1   = 7'h01;
    localparam logic [6:0] OFS_PCL    = 7'h02;
    localparam logic [6:0] OFS_FLAGS  = 7'h03;
    localparam logic [6:0] OFS_P0L    = 7'h04;
    localparam logic [6:0] OFS_P0H    = 7'h05;
    localparam logic [6:0] OFS_P1L    = 7'h06;
    localparam logic [6:0] OFS_P1H    = 7'h07;
    localparam logic [6:0] OFS_BSEL   = 7'h08;
    localparam logic [6:0] OFS_ACC    = 7'h09;
    localparam logic [6:0] OFS_PCH    = 7'h0A;
    localparam logic [6:0] OFS_INTC   = 7'h0B;
    localparam logic [6:0] OFS_SFR_LO = 7'h0C;
    localparam logic [6:0] OFS_SFR_HI = 7'h1F;
    localparam logic [6:0] OFS_GPR_LO = 7'h20;
    localparam logic [6:0] OFS_GPR_HI = 7'h6F;
    localparam logic [6:0] OFS_COM_LO = 7'h70;

    localparam int GPR_BYTES = 80;
    localparam int COM_BYTES = 16;

    // indirect pointer: linear window for general purpose ram
    localparam logic [15:0] LIN_BASE = 16'h2000;
    localparam logic [15:0] LIN_TOP  = 16'h29AF;
    localparam logic [3:0]  LIN_SEL  = 4'h2;

    // flag register fields
    localparam int FB_TO = 4;
    localparam int FB_PD = 3;
    localparam int FB_Z  = 2;
    localparam int FB_DC = 1;
    localparam int FB_C  = 0;
    localparam logic [7:0] FLAGS_IMPL = 8'h1F;

    typedef enum logic [3:0] {
        CRB_OP_NONE = 4'h0,
        CRB_OP_ADD  = 4'h1,
        CRB_OP_SUB  = 4'h2,
        CRB_OP_RRF  = 4'h3,
        CRB_OP_RLF  = 4'h4,
        CRB_OP_AND  = 4'h5,
        CRB_OP_IOR  = 4'h6,
        CRB_OP_XOR  = 4'h7,
        CRB_OP_CLR  = 4'h8,
        CRB_OP_MOV  = 4'h9,
        CRB_OP_INC  = 4'hA
    } crb_op_e;

    // one executed instruction from the core
    typedef struct packed {
        logic       valid;
        crb_op_e    op;
        logic [7:0] a;
        logic [7:0] b;
        logic       to_file;
        logic       indirect;
        logic [1:0] ptr_sel;
        logic [6:0] ofs;
    } crb_exec_s;

    typedef struct packed {
        logic [7:0] result;
        logic       z;
        logic       dc;
        logic       c;
        logic       upd_z;
        logic       upd_dc;
        logic       upd_c;
    } crb_alu_s;

    typedef struct packed {
        logic       power_up;
        logic       wdt_clear;
        logic       sleep;
        logic       wdt_timeout;
    } crb_evt_s;

endpackage : crb_pkg

// >>> logic/crb_alu.sv
`timescale 1ns/1ps
`default_nettype none
module crb_alu (
    // operation
    input  wire crb_pkg::crb_op_e op,
    input  wire logic [7:0]       a,
    input  wire logic [7:0]       b,
    input  wire logic             c_in,
    // result
    output crb_pkg::crb_alu_s     res
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] opb;
    logic       cin;

    always_comb begin
        // subtraction adds two's complement, carries become inverted borrows
        opb = (op == crb_pkg::CRB_OP_SUB) ? ~b : b;
        cin = (op == crb_pkg::CRB_OP_SUB);
        sum = {1'b0, a} + {1'b0, opb} + {8'h00, cin};
        nib = {1'b0, a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        res = '0;
        case (op)
            crb_pkg::CRB_OP_ADD, crb_pkg::CRB_OP_SUB: begin
                res.result = sum[7:0];
                res.dc     = nib[4];
                res.c      = sum[8];
                res.upd_z  = 1'b1;
                res.upd_dc = 1'b1;
                res.upd_c  = 1'b1;
            end
            crb_pkg::CRB_OP_RRF: begin
                res.result = {c_in, a[7:1]};
                res.c      = a[0];
                res.upd_c  = 1'b1;
            end
            crb_pkg::CRB_OP_RLF: begin
                res.result = {a[6:0], c_in};
                res.c      = a[7];
                res.upd_c  = 1'b1;
            end
            crb_pkg::CRB_OP_AND: begin
                res.result = a & b;
                res.upd_z  = 1'b1;
            end
            crb_pkg::CRB_OP_IOR: begin
                res.result = a | b;
                res.upd_z  = 1'b1;
            end
            crb_pkg::CRB_OP_XOR: begin
                res.result = a ^ b;
                res.upd_z  = 1'b1;
            end
            crb_pkg::CRB_OP_INC: begin
                res.result = a + 8'h01;
                res.upd_z  = 1'b1;
            end
            crb_pkg::CRB_OP_CLR: begin
                res.result = 8'h00;
                res.upd_z  = 1'b1;
            end
            crb_pkg::CRB_OP_MOV: begin
                res.result = b;
            end
            default: begin
                res.result = a;
            end
        endcase
        res.z = (res.result == 8'h00);
    end
endmodule : crb_alu
`default_nettype wire

// >>> logic/crb_ram.sv
`timescale 1ns/1ps
`default_nettype none
module crb_ram #(
    parameter int DEPTH = 656,
    parameter int AW    = 10
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          reset_n,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // read port
    input  wire logic [AW-1:0] raddr,
    output logic [7:0]         rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (we && (int'(waddr) < DEPTH)) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = (int'(raddr) < DEPTH) ? mem[raddr] : 8'h00;
endmodule : crb_ram
`default_nettype wire

// >>> logic/crb_core_regs.sv
// How it works
// - core registers at offsets 00-0B every bank
// - flag register accepts any instruction destination
// - flag-updating writes keep computed Z,DC,C
// - software writes to timeout/power-down ignored
// - flag bits 7-5 read zero
// - timeout flag set powerup/clear/sleep, cleared timeout
// - power-down flag set powerup/clear, cleared sleep
// - zero flag follows result equals zero
// - digit carry from bit 3 on add/sub
// - carry from bit 7 on add/sub
// - subtract adds complement, carries are inverted borrows
// - rotates load carry from source end bit
// - clear of flags zeroes top, sets Z
// - peripheral registers at offsets 0C-1F every bank
// - eighty bytes general RAM per bank
// - sixteen common bytes shared by all banks
// - pointers reach general RAM linearly
// - thirty-two banks of 128, chosen by selector
// - unimplemented locations read zero
`timescale 1ns/1ps
`default_nettype none
module crb_core_regs #(
    parameter int GPR_DEPTH = crb_pkg::BANKS * crb_pkg::GPR_BYTES
) (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    // instruction from the core
    input  wire crb_pkg::crb_exec_s    exec,
    // hardware reset-cause events
    input  wire crb_pkg::crb_evt_s     evt,
    // peripheral register window
    input  wire logic [7:0]            sfr_rdata,
    output logic                       sfr_we,
    output logic [4:0]                 sfr_bank,
    output logic [6:0]                 sfr_ofs,
    output logic [7:0]                 sfr_wdata,
    // results back to the core
    output logic [7:0]                 result,
    output logic [7:0]                 flags,
    output logic [7:0]                 accumulator,
    output logic [7:0]                 bank_selector,
    output logic [7:0]                 operand
);
    localparam int RAM_W = $clog2(GPR_DEPTH + crb_pkg::COM_BYTES);

    logic [7:0] program_counter_low;
    logic [7:0] pointer_zero_low;
    logic [7:0] pointer_zero_high;
    logic [7:0] pointer_one_low;
    logic [7:0] pointer_one_high;
    logic [7:0] program_counter_high_latch;
    logic [7:0] interrupt_control;
    logic [7:0] working_accumulator;
    logic [4:0] bsel;
    logic       watchdog_timeout_flag;
    logic       power_down_flag;
    logic       zero_flag;
    logic       digit_carry_flag;
    logic       carry_flag;

    crb_pkg::crb_alu_s alu;
    logic [7:0]        flags_now;
    logic [4:0]        eff_bank;
    logic [6:0]        eff_ofs;
    logic              lin_hit;
    logic [RAM_W-1:0]  ram_addr;
    logic              ram_hit;
    logic [7:0]        ram_rdata;
    logic [7:0]        rd_val;
    logic              wr;
    logic              ptr_miss;
    logic [15:0]       ptr;
    logic [15:0]       lin_ofs;

    function automatic logic [RAM_W-1:0] gpr_index(input logic [4:0] bank, input logic [6:0] ofs);
        gpr_index = RAM_W'(int'(bank) * crb_pkg::GPR_BYTES + int'(ofs - crb_pkg::OFS_GPR_LO));
    endfunction : gpr_index

    function automatic logic is_core(input logic [6:0] ofs);
        is_core = (ofs <= crb_pkg::OFS_INTC);
    endfunction : is_core

    assign flags_now = {3'b000, watchdog_timeout_flag, power_down_flag,
                        zero_flag, digit_carry_flag, carry_flag};

    // address resolution: direct uses bank selector, indirect uses a pointer
    always_comb begin
        ptr      = exec.ptr_sel[0] ? {pointer_one_high, pointer_one_low}
                                   : {pointer_zero_high, pointer_zero_low};
        lin_ofs  = ptr - crb_pkg::LIN_BASE;
        lin_hit  = 1'b0;
        ptr_miss = 1'b0;
        eff_bank = bsel;
        eff_ofs  = exec.ofs;
        if (exec.indirect) begin
            if (ptr[15:12] == crb_pkg::LIN_SEL) begin
                lin_hit  = (ptr <= crb_pkg::LIN_TOP);
                ptr_miss = !lin_hit;
            end else if (ptr[15:12] == 4'h0) begin
                eff_bank = ptr[11:7];
                eff_ofs  = ptr[6:0];
            end else begin
                ptr_miss = 1'b1;
            end
        end
    end

    always_comb begin
        ram_hit  = 1'b0;
        ram_addr = '0;
        if (lin_hit) begin
            ram_hit  = (int'(lin_ofs) < GPR_DEPTH);
            ram_addr = RAM_W'(lin_ofs);
        end else if (!ptr_miss && eff_ofs >= crb_pkg::OFS_COM_LO) begin
            ram_hit  = 1'b1;
            ram_addr = RAM_W'(GPR_DEPTH + int'(eff_ofs - crb_pkg::OFS_COM_LO));
        end else if (!ptr_miss && eff_ofs >= crb_pkg::OFS_GPR_LO) begin
            ram_hit  = 1'b1;
            ram_addr = gpr_index(eff_bank, eff_ofs);
        end
    end

    // operand fetch; indirect through an indirect port itself reads zero
    always_comb begin
        rd_val = 8'h00;
        if (ram_hit) begin
            rd_val = ram_rdata;
        end else if (!ptr_miss && !lin_hit && is_core(eff_ofs) && !exec.indirect) begin
            case (eff_ofs)
                crb_pkg::OFS_PCL:   rd_val = program_counter_low;
                crb_pkg::OFS_FLAGS: rd_val = flags_now;
                crb_pkg::OFS_P0L:   rd_val = pointer_zero_low;
                crb_pkg::OFS_P0H:   rd_val = pointer_zero_high;
                crb_pkg::OFS_P1L:   rd_val = pointer_one_low;
                crb_pkg::OFS_P1H:   rd_val = pointer_one_high;
                crb_pkg::OFS_BSEL:  rd_val = {3'b000, bsel};
                crb_pkg::OFS_ACC:   rd_val = working_accumulator;
                crb_pkg::OFS_PCH:   rd_val = program_counter_high_latch;
                crb_pkg::OFS_INTC:  rd_val = interrupt_control;
                default:            rd_val = 8'h00;
            endcase
        end else if (!ptr_miss && !lin_hit && eff_ofs <= crb_pkg::OFS_SFR_HI && !is_core(eff_ofs)) begin
            rd_val = sfr_rdata;
        end
    end

    crb_alu u_alu (
        .op   (exec.op),
        .a    (exec.to_file ? rd_val : exec.a),
        .b    (exec.b),
        .c_in (carry_flag),
        .res  (alu)
    );

    crb_ram #(
        .DEPTH (GPR_DEPTH + crb_pkg::COM_BYTES),
        .AW    (RAM_W)
    ) u_ram (
        .mclk    (mclk),
        .reset_n (reset_n),
        .we      (wr && ram_hit),
        .waddr   (ram_addr),
        .wdata   (alu.result),
        .raddr   (ram_addr),
        .rdata   (ram_rdata)
    );

    assign wr = exec.valid && exec.to_file && !ptr_miss;

    function automatic logic core_wr(input logic w, input logic ind, input logic [6:0] o, input logic [6:0] t);
        core_wr = w && !ind && (o == t);
    endfunction : core_wr

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            program_counter_low        <= 8'h00;
            pointer_zero_low           <= 8'h00;
            pointer_zero_high          <= 8'h00;
            pointer_one_low            <= 8'h00;
            pointer_one_high           <= 8'h00;
            program_counter_high_latch <= 8'h00;
            interrupt_control          <= 8'h00;
            bsel                       <= 5'h00;
        end else begin
            if (core_wr(wr, exec.indirect, eff_ofs, crb_pkg::OFS_PCL))  program_counter_low        <= alu.result;
            if (core_wr(wr, exec.indirect, eff_ofs, crb_pkg::OFS_P0L))  pointer_zero_low           <= alu.result;
            if (core_wr(wr, exec.indirect, eff_ofs, crb_pkg::OFS_P0H))  pointer_zero_high          <= alu.result;
            if (core_wr(wr, exec.indirect, eff_ofs, crb_pkg::OFS_P1L))  pointer_one_low            <= alu.result;
            if (core_wr(wr, exec.indirect, eff_ofs, crb_pkg::OFS_P1H))  pointer_one_high           <= alu.result;
            if (core_wr(wr, exec.indirect, eff_ofs, crb_pkg::OFS_PCH))  program_counter_high_latch <= alu.result;
            if (core_wr(wr, exec.indirect, eff_ofs, crb_pkg::OFS_INTC)) interrupt_control          <= alu.result;
            if (core_wr(wr, exec.indirect, eff_ofs, crb_pkg::OFS_BSEL)) bsel <= alu.result[4:0];
        end
    end

    // accumulator is destination when not to_file, or when addressed as a file
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            working_accumulator <= 8'h00;
        end else if (exec.valid && !exec.to_file) begin
            working_accumulator <= alu.result;
        end else if (core_wr(wr, exec.indirect, eff_ofs, crb_pkg::OFS_ACC)) begin
            working_accumulator <= alu.result;
        end
    end

    // arithmetic flags: computed value wins over the written value
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            zero_flag        <= 1'b0;
            digit_carry_flag <= 1'b0;
            carry_flag       <= 1'b0;
        end else if (exec.valid) begin
            if (core_wr(wr, exec.indirect, eff_ofs, crb_pkg::OFS_FLAGS)
                    && !(alu.upd_z || alu.upd_dc || alu.upd_c)) begin
                // bits 7-5 and the two reset flags of the written value are dropped
                zero_flag        <= alu.result[crb_pkg::FB_Z];
                digit_carry_flag <= alu.result[crb_pkg::FB_DC];
                carry_flag       <= alu.result[crb_pkg::FB_C];
            end else begin
                if (alu.upd_z)  zero_flag        <= alu.z;
                if (alu.upd_dc) digit_carry_flag <= alu.dc;
                if (alu.upd_c)  carry_flag       <= alu.c;
            end
        end
    end

    // reset-cause flags move only on hardware events; timeout wins over clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_timeout_flag <= 1'b1;
            power_down_flag       <= 1'b1;
        end else begin
            if (evt.wdt_timeout)
                watchdog_timeout_flag <= 1'b0;
            else if (evt.power_up || evt.wdt_clear || evt.sleep)
                watchdog_timeout_flag <= 1'b1;
            if (evt.power_up || evt.wdt_clear)
                power_down_flag <= 1'b1;
            else if (evt.sleep)
                power_down_flag <= 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_we    <= 1'b0;
            sfr_bank  <= 5'h00;
            sfr_ofs   <= 7'h00;
            sfr_wdata <= 8'h00;
            result    <= 8'h00;
            operand   <= 8'h00;
        end else begin
            sfr_we    <= wr && !lin_hit && !is_core(eff_ofs) && (eff_ofs <= crb_pkg::OFS_SFR_HI);
            sfr_bank  <= eff_bank;
            sfr_ofs   <= eff_ofs;
            sfr_wdata <= alu.result;
            if (exec.valid) begin
                result  <= alu.result;
                operand <= rd_val;
            end
        end
    end

    assign flags         = flags_now;
    assign accumulator   = working_accumulator;
    assign bank_selector = {3'b000, bsel};
endmodule : crb_core_regs
`default_nettype wire

// >>> tb/crb_sfr_model.sv
`timescale 1ns/1ps
`default_nettype none
module crb_sfr_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // write side from the bank
    input  wire logic       sfr_we,
    input  wire logic [4:0] sfr_bank,
    input  wire logic [6:0] sfr_ofs,
    input  wire logic [7:0] sfr_wdata,
    // read side
    input  wire logic [4:0] rd_bank,
    input  wire logic [6:0] rd_ofs,
    output logic [7:0]      sfr_rdata
);
    logic [7:0] regs [0:1023];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 1024; i++) regs[i] <= 8'h00;
        end else if (sfr_we) begin
            regs[{sfr_bank, sfr_ofs[4:0]}] <= sfr_wdata;
        end
    end

    // outside the peripheral window the bus carries junk, so a leak into other reads shows up
    always_comb begin
        if (rd_ofs >= 7'h0C && rd_ofs <= 7'h1F) sfr_rdata = regs[{rd_bank, rd_ofs[4:0]}];
        else sfr_rdata = ~regs[{rd_bank, rd_ofs[4:0]}];
    end
endmodule : crb_sfr_model
`default_nettype wire

// >>> tb/crb_core_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module crb_core_regs_chk (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               reset_n,
    // core side
    input  wire crb_pkg::crb_exec_s exec,
    input  wire crb_pkg::crb_evt_s  evt,
    // peripheral window
    input  wire logic [7:0]         sfr_rdata,
    input  wire logic               sfr_we,
    input  wire logic [4:0]         sfr_bank,
    input  wire logic [6:0]         sfr_ofs,
    input  wire logic [7:0]         sfr_wdata,
    // results
    input  wire logic [7:0]         result,
    input  wire logic [7:0]         flags,
    input  wire logic [7:0]         accumulator,
    input  wire logic [7:0]         bank_selector,
    input  wire logic [7:0]         operand
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    logic acc_op;
    assign acc_op = exec.valid && !exec.to_file;

    property p_unimpl; flags[7:5] == 3'h0 && bank_selector[7:5] == 3'h0; endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits not zero");
    property p_add_c; acc_op && exec.op == crb_pkg::CRB_OP_ADD
        |=> {flags[0], accumulator} == $past({1'h0, exec.a} + {1'h0, exec.b}); endproperty
    a_add_c: assert property (p_add_c) else $error("add sum or carry wrong");
    property p_add_dc; acc_op && exec.op == crb_pkg::CRB_OP_ADD
        |=> flags[1] == $past(({1'h0, exec.a[3:0]} + {1'h0, exec.b[3:0]}) > 5'h0F); endproperty
    a_add_dc: assert property (p_add_dc) else $error("digit carry wrong");
    property p_zero; acc_op && (exec.op == crb_pkg::CRB_OP_ADD || exec.op == crb_pkg::CRB_OP_SUB)
        |=> flags[2] == (accumulator == 8'h00); endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_sub; acc_op && exec.op == crb_pkg::CRB_OP_SUB
        |=> {flags[0], accumulator} == $past({1'h0, exec.a} + {1'h0, ~exec.b} + 9'h001); endproperty
    a_sub: assert property (p_sub) else $error("subtract or borrow wrong");
    property p_rot; acc_op && (exec.op == crb_pkg::CRB_OP_RRF || exec.op == crb_pkg::CRB_OP_RLF)
        |=> flags[0] == $past(exec.op == crb_pkg::CRB_OP_RRF ? exec.a[0] : exec.a[7]); endproperty
    a_rot: assert property (p_rot) else $error("rotate carry wrong");
    property p_to_clr; evt.wdt_timeout |=> !flags[4]; endproperty
    a_to_clr: assert property (p_to_clr) else $error("timeout flag not cleared");
    property p_to_set; (evt.power_up || evt.wdt_clear || evt.sleep) && !evt.wdt_timeout |=> flags[4]; endproperty
    a_to_set: assert property (p_to_set) else $error("timeout flag not set");
    property p_pd; evt.sleep || evt.power_up || evt.wdt_clear
        |=> flags[3] == $past(evt.power_up || evt.wdt_clear); endproperty
    a_pd: assert property (p_pd) else $error("power-down flag wrong");
    property p_hold; evt == 4'h0 |=> $stable(flags[4:3]); endproperty
    a_hold: assert property (p_hold) else $error("reset flags changed without event");
    property p_sfr; exec.valid && exec.to_file && !exec.indirect && exec.op == crb_pkg::CRB_OP_MOV
        && exec.ofs >= 7'h0C && exec.ofs <= 7'h1F |=> sfr_we && sfr_ofs == $past(exec.ofs)
        && sfr_bank == $past(bank_selector[4:0]) && sfr_wdata == $past(exec.b); endproperty
    a_sfr: assert property (p_sfr) else $error("peripheral write not issued");
endmodule : crb_core_regs_chk

bind crb_core_regs crb_core_regs_chk crb_core_regs_chk_inst (.mclk(mclk), .reset_n(reset_n), .exec(exec),
    .evt(evt), .sfr_rdata(sfr_rdata), .sfr_we(sfr_we), .sfr_bank(sfr_bank), .sfr_ofs(sfr_ofs),
    .sfr_wdata(sfr_wdata), .result(result), .flags(flags), .accumulator(accumulator),
    .bank_selector(bank_selector), .operand(operand));
`default_nettype wire

// >>> tb/test_core_register_status_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_core_register_status_bank;
    logic               mclk      = 1'b0;
    logic               reset_n   = 1'b0;
    crb_pkg::crb_exec_s exec      = '0;
    crb_pkg::crb_evt_s  evt       = '0;
    logic [7:0]         sfr_rdata;
    logic               sfr_we;
    logic [4:0]         sfr_bank;
    logic [6:0]         sfr_ofs;
    logic [7:0]         sfr_wdata, result, flags, accumulator, bank_selector, operand;
    int                 fail_count = 0;
    int                 n_tests    = 0;

    always #10 mclk = ~mclk;

    crb_core_regs crb_core_regs_inst (.mclk(mclk), .reset_n(reset_n), .exec(exec), .evt(evt),
        .sfr_rdata(sfr_rdata), .sfr_we(sfr_we), .sfr_bank(sfr_bank), .sfr_ofs(sfr_ofs), .sfr_wdata(sfr_wdata),
        .result(result), .flags(flags), .accumulator(accumulator), .bank_selector(bank_selector),
        .operand(operand));
    crb_sfr_model crb_sfr_model_inst (.mclk(mclk), .reset_n(reset_n), .sfr_we(sfr_we), .sfr_bank(sfr_bank),
        .sfr_ofs(sfr_ofs), .sfr_wdata(sfr_wdata), .rd_bank(bank_selector[4:0]), .rd_ofs(exec.ofs),
        .sfr_rdata(sfr_rdata));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // valid is up for exactly one taking edge; results are read at the falling edge after it
    task automatic ex(input crb_pkg::crb_op_e o, input logic [7:0] a, input logic [7:0] b, input logic tf,
                      input logic [6:0] ofs, input logic ind, input logic [1:0] ps);
        @(negedge mclk);
        exec = '{1'b1, o, a, b, tf, ind, ps, ofs};
        @(negedge mclk);
        exec.valid = 1'b0;
    endtask : ex

    task automatic wr(input logic [6:0] ofs, input logic [7:0] v);
        ex(crb_pkg::CRB_OP_MOV, 8'h00, v, 1'b1, ofs, 1'b0, 2'h0);
    endtask : wr

    // and with all ones leaves the file unchanged and shows it on operand
    task automatic rd(input string what, input logic [6:0] ofs, input logic [7:0] exp);
        ex(crb_pkg::CRB_OP_AND, 8'h00, 8'hFF, 1'b1, ofs, 1'b0, 2'h0);
        chk(what, exp, operand);
        chk(what, exp, result);
    endtask : rd

    task automatic alu(input crb_pkg::crb_op_e o, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] acc, input logic [2:0] f3);
        ex(o, a, b, 1'b0, 7'h00, 1'b0, 2'h0);
        chk("accumulator", acc, accumulator);
        chk("z_dc_c", {5'h00, f3}, flags & 8'h07);
    endtask : alu

    task automatic pulse(input crb_pkg::crb_evt_s e, input logic [1:0] exp);
        @(negedge mclk);
        evt = e;
        @(negedge mclk);
        evt = '0;
        chk("timeout_powerdown", {6'h00, exp}, {6'h00, flags[4:3]});
    endtask : pulse

    task automatic t_reset;
        chk("flags", 8'h18, flags);
        chk("accumulator", 8'h00, accumulator);
        chk("bank_selector", 8'h00, bank_selector);
        $display("done t_reset");
    endtask : t_reset

    task automatic t_arith;
        alu(crb_pkg::CRB_OP_ADD, 8'h0F, 8'h01, 8'h10, 3'h2);
        alu(crb_pkg::CRB_OP_ADD, 8'hFF, 8'h01, 8'h00, 3'h7);
        alu(crb_pkg::CRB_OP_SUB, 8'h05, 8'h06, 8'hFF, 3'h0);
        alu(crb_pkg::CRB_OP_SUB, 8'h06, 8'h05, 8'h01, 3'h3);
        alu(crb_pkg::CRB_OP_SUB, 8'h05, 8'h05, 8'h00, 3'h7);
        alu(crb_pkg::CRB_OP_XOR, 8'h5A, 8'hA5, 8'hFF, 3'h3);
        ex(crb_pkg::CRB_OP_RRF, 8'h01, 8'h00, 1'b0, 7'h00, 1'b0, 2'h0);
        chk("carry", 8'h01, {7'h00, flags[0]});
        ex(crb_pkg::CRB_OP_RLF, 8'h01, 8'h00, 1'b0, 7'h00, 1'b0, 2'h0);
        chk("carry", 8'h00, {7'h00, flags[0]});
        ex(crb_pkg::CRB_OP_RLF, 8'h80, 8'h00, 1'b0, 7'h00, 1'b0, 2'h0);
        chk("carry", 8'h01, {7'h00, flags[0]});
        $display("done t_arith");
    endtask : t_arith

    task automatic t_flag_writes;
        wr(crb_pkg::OFS_FLAGS, 8'hFF);
        chk("flags", 8'h1F, flags);
        wr(crb_pkg::OFS_FLAGS, 8'hE0);
        chk("flags", 8'h18, flags);
        ex(crb_pkg::CRB_OP_ADD, 8'h00, 8'hE8, 1'b1, crb_pkg::OFS_FLAGS, 1'b0, 2'h0);
        chk("flags", 8'h1F, flags);
        wr(crb_pkg::OFS_FLAGS, 8'h03);
        ex(crb_pkg::CRB_OP_CLR, 8'h00, 8'h00, 1'b1, crb_pkg::OFS_FLAGS, 1'b0, 2'h0);
        chk("flags", 8'h1F, flags);
        $display("done t_flag_writes");
    endtask : t_flag_writes

    task automatic t_events;
        pulse('{1'b0, 1'b0, 1'b1, 1'b0}, 2'h2);
        pulse('{1'b0, 1'b0, 1'b0, 1'b1}, 2'h0);
        pulse('{1'b0, 1'b1, 1'b0, 1'b0}, 2'h3);
        pulse('{1'b0, 1'b0, 1'b1, 1'b0}, 2'h2);
        pulse('{1'b1, 1'b0, 1'b0, 1'b0}, 2'h3);
        $display("done t_events");
    endtask : t_events

    task automatic t_banks;
        wr(crb_pkg::OFS_BSEL, 8'hFF);
        chk("bank_selector", 8'h1F, bank_selector);
        wr(crb_pkg::OFS_BSEL, 8'h05);
        wr(7'h20, 8'hA5);
        wr(7'h0C, 8'h5A);
        chk("sfr_we", 8'h01, {7'h00, sfr_we});
        chk("sfr_bank", 8'h05, {3'h0, sfr_bank});
        chk("sfr_ofs", 8'h0C, {1'h0, sfr_ofs});
        chk("sfr_wdata", 8'h5A, sfr_wdata);
        wr(crb_pkg::OFS_BSEL, 8'h06);
        rd("gpr_other_bank", 7'h20, 8'h00);
        wr(7'h70, 8'h3C);
        wr(crb_pkg::OFS_PCH, 8'h77);
        rd("sfr_other_bank", 7'h0C, 8'h00);
        wr(crb_pkg::OFS_BSEL, 8'h05);
        rd("gpr_own_bank", 7'h20, 8'hA5);
        rd("common_ram", 7'h7F - 7'h0F, 8'h3C);
        rd("core_register", crb_pkg::OFS_PCH, 8'h77);
        rd("sfr_own_bank", 7'h0C, 8'h5A);
        $display("done t_banks");
    endtask : t_banks

    task automatic t_linear;
        wr(crb_pkg::OFS_P0L, 8'h50);
        wr(crb_pkg::OFS_P0H, 8'h20);
        ex(crb_pkg::CRB_OP_MOV, 8'h00, 8'h99, 1'b1, 7'h00, 1'b1, 2'h0);
        wr(crb_pkg::OFS_BSEL, 8'h01);
        rd("linear_to_bank", 7'h20, 8'h99);
        wr(crb_pkg::OFS_P1L, 8'hB0);
        wr(crb_pkg::OFS_P1H, 8'h29);
        ex(crb_pkg::CRB_OP_AND, 8'h00, 8'hFF, 1'b1, 7'h00, 1'b1, 2'h1);
        chk("past_linear_top", 8'h00, operand);
        ex(crb_pkg::CRB_OP_AND, 8'h00, 8'hFF, 1'b1, 7'h00, 1'b1, 2'h0);
        chk("linear_read", 8'h99, operand);
        $display("done t_linear");
    endtask : t_linear

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // the sequence needs well under 200 cycles
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        t_reset();
        t_arith();
        t_flag_writes();
        t_events();
        t_banks();
        t_linear();
        stop_test();
    end
endmodule : test_core_register_status_bank
`default_nettype wire
